// File: sff_ctrl.sv
// Serial flash fetch controller: boot check, fetch engine, prefetch
// cache, buffered command engine and register port.
// Assumes one clock; flash input pins are asynchronous to it.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module sff_ctrl #(
  parameter int CLK_HZ    = sff_pkg::CLK_HZ,
  parameter int SCLK_HALF = sff_pkg::SCLK_HALF
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        fetch_req,
  input  wire logic [23:0] fetch_addr,
  output logic             fetch_ready,
  output logic      [7:0]  fetch_data,
  output logic             ext_exec_en,
  output logic             flash_sclk,
  output logic             flash_select_n,
  output logic             flash_serial_out,
  output logic             flash_serial_out_oe,
  input  wire logic        flash_serial_out_in,
  input  wire logic        flash_serial_in
);

  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_WAIT, S_END} sff_state_t;

  localparam bit         DUAL_OK   = (CLK_HZ / (2 * SCLK_HALF)) == sff_pkg::DUAL_HZ;
  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
  localparam logic [2:0] CEH_LAST  = 3'(sff_pkg::CEH_CYC - 1);
  localparam logic [10:0] HDR_END  = 11'(sff_pkg::HDR_BITS);
  localparam logic [5:0] LEN_FULL  = 6'(sff_pkg::CACHE_BYTES);

  sff_state_t  state_reg;
  logic [7:0]  half_reg;
  logic        sclk_reg;
  logic        cs_n_reg;
  logic        si_m_reg, si_s_reg, so_m_reg, so_s_reg;
  logic [10:0] bit_idx_reg;
  logic [2:0]  dbit_reg;
  logic        byte_done_reg;
  logic [7:0]  rx_reg;
  logic        out_reg, oe_reg;
  logic        kind_buf_reg, dual_x_reg;
  logic [39:0] hdr_reg;
  logic [23:0] last_reg;
  logic [2:0]  ceh_reg;
  logic [23:0] base_reg;
  logic [5:0]  len_reg;
  logic [7:0]  cache_mem [sff_pkg::CACHE_BYTES];
  logic        pend_reg, kick_reg;
  logic [23:0] pend_addr_reg;
  logic [2:0]  boot_cnt_reg;
  logic [31:0] sig_reg;
  logic        booted_reg, boot_fin_reg, ext_reg;
  logic        ready_reg;
  logic [7:0]  data_reg;
  logic        launch_reg, dual_mode_reg;
  logic [7:0]  count_reg;
  logic [63:0] cmd_reg, resp_reg;
  logic [31:0] rdata_reg;
  logic [10:0] clk_seen_reg;

  logic        tick, rise, fall, data_ph, use_dual, seq, hit, cont;
  logic        start_fetch, start_buf, resume, close, hit_take;
  logic        fetch_end, buf_end, launch_set, launch_clr;
  logic [10:0] total;
  logic [2:0]  dbit_last;
  logic [7:0]  rx_dual, rx_single;

  // Next serial output bit for either transfer kind
  function automatic logic nxt_bit(input logic buf_mode, input logic [10:0] idx,
                                   input logic [63:0] cmd, input logic [39:0] hdr);
    logic [5:0] pos;
    pos = {idx[5:3], ~idx[2:0]};
    if (buf_mode)
      nxt_bit = (idx[10:3] < 8'(sff_pkg::CMD_BYTES)) ? cmd[pos] : sff_pkg::FILL_BIT;
    else
      nxt_bit = (idx < HDR_END) ? hdr[6'd39 - idx[5:0]] : sff_pkg::FILL_BIT;
  endfunction : nxt_bit

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign tick        = (state_reg == S_SHIFT) && (half_reg == HALF_LAST);
  assign rise        = tick && !sclk_reg;
  assign fall        = tick && sclk_reg;
  assign data_ph     = !kind_buf_reg && (bit_idx_reg == HDR_END);
  assign use_dual    = dual_mode_reg && DUAL_OK && booted_reg;
  assign total       = {count_reg, 3'h0};
  assign dbit_last   = dual_x_reg ? 3'h3 : 3'h7;
  assign rx_dual     = {rx_reg[5:0], si_s_reg, so_s_reg};
  assign rx_single   = {rx_reg[6:0], si_s_reg};
  assign seq         = pend_addr_reg == last_reg + 24'h1;
  assign hit         = (len_reg != 6'h0) && ((pend_addr_reg - base_reg) < {18'h0, len_reg});
  assign cont        = (len_reg != 6'h0) && (pend_addr_reg == base_reg + {18'h0, len_reg});
  assign start_buf   = (state_reg == S_IDLE) && launch_reg && (count_reg != 8'h00);
  assign start_fetch = (state_reg == S_IDLE) && pend_reg && !hit && !start_buf;
  assign resume      = (state_reg == S_WAIT) && pend_reg && seq;
  assign close       = (state_reg == S_WAIT) && !resume && (pend_reg || launch_reg || boot_fin_reg);
  assign hit_take    = pend_reg && hit && !resume &&
                       ((state_reg == S_IDLE) || (state_reg == S_WAIT));
  assign fetch_end   = fall && data_ph && byte_done_reg;
  assign buf_end     = fall && kind_buf_reg && (bit_idx_reg == total);

  // ---------------------------------------------------------------
  // Pin synchronisers and serial clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      si_m_reg <= 1'b0;
      si_s_reg <= 1'b0;
      so_m_reg <= 1'b0;
      so_s_reg <= 1'b0;
    end else begin
      si_m_reg <= flash_serial_in;
      si_s_reg <= si_m_reg;
      so_m_reg <= flash_serial_out_in;
      so_s_reg <= so_m_reg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      half_reg <= 8'h00;
      sclk_reg <= 1'b0;
    end else if (state_reg != S_SHIFT) begin
      half_reg <= 8'h00;
      sclk_reg <= 1'b0;
    end else begin
      half_reg <= tick ? 8'h00 : half_reg + 8'h01;
      if (tick)
        sclk_reg <= !sclk_reg;
    end
  end

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= S_IDLE;
      cs_n_reg     <= 1'b1;
      kind_buf_reg <= 1'b0;
      dual_x_reg   <= 1'b0;
      hdr_reg      <= 40'h0;
      last_reg     <= 24'h0;
      ceh_reg      <= 3'h0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          ceh_reg <= 3'h0;
          if (start_buf) begin
            state_reg    <= S_SHIFT;
            cs_n_reg     <= 1'b0;
            kind_buf_reg <= 1'b1;
          end else if (start_fetch) begin
            state_reg    <= S_SHIFT;
            cs_n_reg     <= 1'b0;
            kind_buf_reg <= 1'b0;
            dual_x_reg   <= use_dual;
            hdr_reg      <= {use_dual ? sff_pkg::OP_DUAL : sff_pkg::OP_READ,
                             pend_addr_reg, sff_pkg::DUMMY_BYTE};
            last_reg     <= pend_addr_reg;
          end
        end
        S_SHIFT: begin
          if (fetch_end) begin
            state_reg <= S_WAIT;
          end else if (buf_end) begin
            state_reg <= S_END;
            cs_n_reg  <= 1'b1;
          end
        end
        S_WAIT: begin
          if (resume) begin
            state_reg <= S_SHIFT;
            last_reg  <= pend_addr_reg;
          end else if (close) begin
            state_reg <= S_END;
            cs_n_reg  <= 1'b1;
          end
        end
        S_END: begin
          if (ceh_reg == CEH_LAST)
            state_reg <= S_IDLE;
          else
            ceh_reg <= ceh_reg + 3'h1;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Shifter
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_idx_reg   <= 11'h0;
      dbit_reg      <= 3'h0;
      byte_done_reg <= 1'b0;
      rx_reg        <= 8'h00;
      out_reg       <= 1'b0;
      oe_reg        <= 1'b0;
    end else if (start_fetch || start_buf) begin
      bit_idx_reg   <= 11'h0;
      dbit_reg      <= 3'h0;
      byte_done_reg <= 1'b0;
      out_reg       <= start_buf ? cmd_reg[7] : sff_pkg::OP_READ[7];
      oe_reg        <= 1'b1;
    end else if (resume) begin
      dbit_reg      <= 3'h0;
      byte_done_reg <= 1'b0;
    end else if (rise) begin
      if (data_ph) begin
        rx_reg   <= dual_x_reg ? rx_dual : rx_single;
        dbit_reg <= dbit_reg + 3'h1;
        if (dbit_reg == dbit_last)
          byte_done_reg <= 1'b1;
      end else begin
        rx_reg      <= rx_single;
        bit_idx_reg <= bit_idx_reg + 11'h1;
      end
    end else if (fall) begin
      out_reg <= nxt_bit(kind_buf_reg, bit_idx_reg, cmd_reg, hdr_reg);
      oe_reg  <= !(data_ph && dual_x_reg);
    end else if (state_reg == S_END) begin
      oe_reg <= 1'b0;
    end
  end

  // Response capture after the command byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      resp_reg <= sff_pkg::BUF_RST;
    else if (rise && kind_buf_reg && (bit_idx_reg[2:0] == 3'h7) &&
             (bit_idx_reg[10:3] != 8'h00) && (bit_idx_reg[10:3] <= 8'(sff_pkg::CMD_BYTES)))
      resp_reg[{3'(bit_idx_reg[5:3] - 3'h1), 3'h0} +: 8] <= rx_single;
  end

  // ---------------------------------------------------------------
  // Prefetch cache
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_reg <= 24'h0;
      len_reg  <= 6'h0;
    end else if (start_fetch && !cont) begin
      base_reg <= pend_addr_reg;
      len_reg  <= 6'h0;
    end else if (fetch_end) begin
      if (len_reg == LEN_FULL)
        base_reg <= base_reg + 24'h1;
      else
        len_reg <= len_reg + 6'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (fetch_end)
      cache_mem[last_reg[4:0]] <= rx_reg;
  end

  // ---------------------------------------------------------------
  // Boot check and request holding
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kick_reg      <= 1'b0;
      pend_reg      <= 1'b0;
      pend_addr_reg <= 24'h0;
      boot_cnt_reg  <= 3'h0;
      sig_reg       <= 32'h0;
      booted_reg    <= 1'b0;
      boot_fin_reg  <= 1'b0;
      ext_reg       <= 1'b0;
    end else begin
      kick_reg     <= 1'b1;
      boot_fin_reg <= 1'b0;
      if (!kick_reg) begin
        pend_reg      <= 1'b1;
        pend_addr_reg <= sff_pkg::BOOT_ADDR;
      end else if (fetch_end && !booted_reg) begin
        sig_reg      <= {sig_reg[23:0], rx_reg};
        boot_cnt_reg <= boot_cnt_reg + 3'h1;
        if (boot_cnt_reg == sff_pkg::SIG_BYTES - 3'h1) begin
          booted_reg   <= 1'b1;
          boot_fin_reg <= 1'b1;
          ext_reg      <= {sig_reg[23:0], rx_reg} == sff_pkg::BOOT_SIG;
        end else begin
          pend_reg      <= 1'b1;
          pend_addr_reg <= last_reg + 24'h1;
        end
      end else if (fetch_req && ext_reg) begin
        pend_reg      <= 1'b1;
        pend_addr_reg <= fetch_addr;
      end else if (hit_take || start_fetch || resume) begin
        pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ready_reg <= 1'b0;
      data_reg  <= 8'h00;
    end else begin
      ready_reg <= (fetch_end && booted_reg) || hit_take;
      if (hit_take)
        data_reg <= cache_mem[pend_addr_reg[4:0]];
      else if (fetch_end && booted_reg)
        data_reg <= rx_reg;
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  assign launch_set = reg_wr && (reg_addr == sff_pkg::OFS_CTRL) &&
                      reg_wdata[sff_pkg::CTRL_LAUNCH];
  assign launch_clr = buf_end || ((state_reg == S_IDLE) && (count_reg == 8'h00));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      launch_reg <= 1'b0;
    else
      launch_reg <= launch_set || (launch_reg && !launch_clr);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dual_mode_reg <= 1'b0;
      count_reg     <= sff_pkg::COUNT_RST;
      cmd_reg       <= sff_pkg::BUF_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        sff_pkg::OFS_CTRL:   dual_mode_reg <= reg_wdata[sff_pkg::CTRL_DUAL];
        sff_pkg::OFS_COUNT:  count_reg <= reg_wdata[7:0];
        sff_pkg::OFS_CMD_LO: cmd_reg[31:0] <= reg_wdata;
        sff_pkg::OFS_CMD_HI: cmd_reg[63:32] <= reg_wdata;
        default: count_reg <= count_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        sff_pkg::OFS_CTRL:    rdata_reg <= {27'h0, state_reg != S_IDLE, booted_reg,
                                            ext_reg, dual_mode_reg, launch_reg};
        sff_pkg::OFS_COUNT:   rdata_reg <= {24'h0, count_reg};
        sff_pkg::OFS_CMD_LO:  rdata_reg <= cmd_reg[31:0];
        sff_pkg::OFS_CMD_HI:  rdata_reg <= cmd_reg[63:32];
        sff_pkg::OFS_RESP_LO: rdata_reg <= resp_reg[31:0];
        sff_pkg::OFS_RESP_HI: rdata_reg <= resp_reg[63:32];
        default:              rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end

  assign reg_rdata           = rdata_reg;
  assign fetch_ready         = ready_reg;
  assign fetch_data          = data_reg;
  assign ext_exec_en         = ext_reg;
  assign flash_sclk          = sclk_reg;
  assign flash_select_n      = cs_n_reg;
  assign flash_serial_out    = out_reg;
  assign flash_serial_out_oe = oe_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      clk_seen_reg <= 11'h0;
    else if (start_buf)
      clk_seen_reg <= 11'h0;
    else if (rise)
      clk_seen_reg <= clk_seen_reg + 11'h1;
  end

  a_idle_deselect: assert property (state_reg == S_IDLE |-> flash_select_n)
    else $error("select low while idle");
  a_single_op: assert property (start_fetch && !use_dual |=>
                                hdr_reg[39:32] == sff_pkg::OP_READ && !flash_select_n)
    else $error("wrong single read opcode");
  a_dual_op: assert property (start_fetch && use_dual |=> hdr_reg[39:32] == sff_pkg::OP_DUAL)
    else $error("wrong dual read opcode");
  a_addr_dummy: assert property (start_fetch |=> hdr_reg[7:0] == sff_pkg::DUMMY_BYTE &&
                                 hdr_reg[31:8] == $past(pend_addr_reg))
    else $error("header address or dummy wrong");
  a_dual_gate: assert property (dual_x_reg && state_reg == S_SHIFT |-> DUAL_OK)
    else $error("dual read at wrong clock rate");
  a_dual_lines: assert property (rise && data_ph && dual_x_reg |=> ##1 !flash_serial_out_oe)
    else $error("data line driven in dual data");
  a_seq_open: assert property (resume |=> state_reg == S_SHIFT ##1 !flash_select_n)
    else $error("sequential fetch closed transfer");
  a_jump_close: assert property (close |=> flash_select_n)
    else $error("jump left transfer open");
  a_base_load: assert property (start_fetch && !cont |=>
                                base_reg == $past(pend_addr_reg) && len_reg == 6'h0)
    else $error("cache base not loaded");
  a_len_cap: assert property (len_reg <= LEN_FULL)
    else $error("cache length overflow");
  a_hit_fast: assert property (hit_take |=> fetch_ready && !$past(start_fetch))
    else $error("cache hit not answered");
  a_buf_clocks: assert property ($rose(flash_select_n) && kind_buf_reg |->
                                 clk_seen_reg == {count_reg, 3'h0})
    else $error("wrong buffered clock count");
  a_launch_poll: assert property ($fell(launch_reg) |-> flash_select_n)
    else $error("launch cleared during transfer");
  a_boot_gate: assert property (booted_reg && !ext_reg |-> !pend_reg)
    else $error("fetch without boot signature");

endmodule : sff_ctrl

// File: sff_ctrl_tb.sv
// Self-checking bench for the serial flash fetch controller.
// Assumes the package, design and flash model are compiled first.
`timescale 1ns/100ps
module sff_ctrl_tb;
  typedef struct packed {logic [23:0] a; logic dual; logic [7:0] op; logic [15:0] lat;} sff_frow_t;
  typedef struct packed {logic [63:0] cmd; logic [7:0] cnt;} sff_brow_t;
  logic        clk, resetn, reg_wr, reg_rd, fetch_req, sig_ok, fetch_ready, ext_exec_en;
  logic        sclk, sel_n, sout, oe, d1, d0, d0_line;
  logic [7:0]  reg_addr, fetch_data;
  logic [7:0]  rx [0:9];
  logic [23:0] fetch_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  int          mismatches, n_compared, cycles, nbits;
  sff_frow_t   frows [0:9] = '{
    '{24'h000000, 1'b0, 8'h0b, 16'd0}, '{24'h000001, 1'b0, 8'h00, 16'd66},
    '{24'h000002, 1'b0, 8'h00, 16'd66}, '{24'h000100, 1'b0, 8'h0b, 16'd0},
    '{24'h000101, 1'b0, 8'h00, 16'd66}, '{24'h000100, 1'b0, 8'h00, 16'd2},
    '{24'h000200, 1'b1, 8'h3b, 16'd0}, '{24'h000201, 1'b1, 8'h00, 16'd34},
    '{24'h000202, 1'b1, 8'h00, 16'd34}, '{24'h000200, 1'b1, 8'h00, 16'd2}};
  sff_brow_t   brows [0:12] = '{
    '{64'h56341220, 8'h04}, '{64'h56341252, 8'h04}, '{64'h563412d8, 8'h04},
    '{64'ha556341202, 8'h05},
    '{64'h06, 8'h01}, '{64'h04, 8'h01}, '{64'h50, 8'h01}, '{64'hc7, 8'h01},
    '{64'h70, 8'h01}, '{64'h80, 8'h01},
    '{64'h8877665544332211, 8'h0a}, '{64'h9f, 8'h09}, '{64'h9f, 8'h04}};
  assign d0_line = oe ? sout : d0;
  sff_ctrl #(.CLK_HZ(240_000_000), .SCLK_HALF(4)) sff_ctrl_inst (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_data(fetch_data),
    .ext_exec_en(ext_exec_en), .flash_sclk(sclk), .flash_select_n(sel_n),
    .flash_serial_out(sout), .flash_serial_out_oe(oe), .flash_serial_out_in(d0_line),
    .flash_serial_in(d1));
  sff_flash_model sff_flash_model_inst (
    .sclk(sclk), .sel_n(sel_n), .di(sout), .sig_ok(sig_ok), .d1(d1), .d0(d0),
    .nbits(nbits), .rx(rx));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : exp_byte
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic fetch(input logic [23:0] a, output int n);
    @(posedge clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch_req <= 1'b0;
    n = 1;
    #1;
    while (fetch_ready !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : fetch
  task automatic xfer(input sff_brow_t r);
    int i;
    wr(sff_pkg::OFS_CMD_LO, r.cmd[31:0]);
    wr(sff_pkg::OFS_CMD_HI, r.cmd[63:32]);
    wr(sff_pkg::OFS_COUNT, {24'h0, r.cnt});
    wr(sff_pkg::OFS_CTRL, 32'h1);
    rd(sff_pkg::OFS_CTRL);
    check(rd_val[0], 1'b1, "launch busy");
    check(rd_val[4], 1'b1, "busy bit");
    for (i = 0; i < 2000 && rd_val[0] !== 1'b0; i++) rd(sff_pkg::OFS_CTRL);
    check(nbits, r.cnt * 8, "clock count");
    check(sel_n, 1'b1, "deselect");
    for (i = 0; i < r.cnt; i++) check(rx[i], i < 8 ? r.cmd[8*i+:8] : 8'h00, "sent byte");
  endtask : xfer
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    int   n, i;
    logic dual;
    {resetn, reg_wr, reg_rd, fetch_req, dual} = '0;
    {reg_addr, reg_wdata, fetch_addr} = '0;
    sig_ok = 1'b1;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (n = 0; n < 1000 && ext_exec_en !== 1'b1; n++) @(posedge clk);
    check(ext_exec_en, 1'b1, "boot enable");
    check({rx[0], rx[1], rx[2], rx[3]}, {8'h0b, sff_pkg::BOOT_ADDR}, "boot read");
    foreach (frows[i]) begin
      if (frows[i].dual !== dual) begin
        dual = frows[i].dual;
        wr(sff_pkg::OFS_CTRL, {30'h0, dual, 1'b0});
      end
      fetch(frows[i].a, n);
      check(fetch_data, exp_byte(frows[i].a), "fetch data");
      if (frows[i].lat != 0) check(n, frows[i].lat, "latency");
      if (frows[i].op != 0) check({rx[0], rx[1], rx[2], rx[3]}, {frows[i].op, frows[i].a}, "header");
    end
    wr(sff_pkg::OFS_CTRL, 32'h0);
    for (i = 0; i < 34; i++) fetch(24'(32'h300 + i), n);
    fetch(24'h000302, n);
    check(n, 2, "slid hit");
    fetch(24'h000301, n);
    check({rx[0], rx[1], rx[2], rx[3]}, {8'h0b, 24'h000301}, "slid miss");
    foreach (brows[i]) xfer(brows[i]);
    rd(sff_pkg::OFS_RESP_LO);
    check(rd_val[23:0], 24'hc3b2a1, "id bytes");
    rd(sff_pkg::OFS_RESP_HI);
    check(rd_val, 32'hc3c3c3c3, "late id bytes");
    rd(sff_pkg::OFS_COUNT);
    check(rd_val[7:0], 8'h04, "count");
    wr(sff_pkg::OFS_COUNT, 32'h0);
    wr(sff_pkg::OFS_CTRL, 32'h1);
    rd(sff_pkg::OFS_CTRL);
    check(rd_val[0], 1'b0, "empty launch");
    check(nbits, 32, "no clocks");
    rd(8'h40);
    check(rd_val, 32'h0, "unmapped");
    @(posedge clk);
    resetn <= 1'b0;
    sig_ok <= 1'b0;
    repeat (20) @(posedge clk);
    check({sel_n, ext_exec_en, fetch_ready}, 3'b100, "reset values");
    resetn <= 1'b1;
    repeat (800) @(posedge clk);
    rd(sff_pkg::OFS_CTRL);
    check(rd_val[3:2], 2'b10, "no signature");
    fetch(24'h000000, n);
    check(n, 1000, "fetch refused");
    conclude();
  end
endmodule : sff_ctrl_tb

// File: sff_flash_model.sv
// Behavioural serial flash facing the fetch controller.
// Assumes mode 0: bits taken on sclk rise, driven after sclk fall.
`timescale 1ns/100ps
module sff_flash_model #(
  parameter logic [7:0] ID0 = 8'ha1,  // Arbitrary value
  parameter logic [7:0] ID1 = 8'hb2,  // Arbitrary value
  parameter logic [7:0] ID2 = 8'hc3   // Arbitrary value
) (
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       di,
  input  wire logic       sig_ok,
  output logic            d1 = 1'b0,
  output logic            d0 = 1'b0,
  output int              nbits = 0,
  output logic      [7:0] rx [0:9]
);
  logic [7:0]  b;
  logic [23:0] a;
  int          k;
  // ----------------------------------------
  // Contents and wire behaviour
  // ----------------------------------------
  function automatic logic [7:0] mem(input logic [23:0] x, input logic ok);
    case (x)
      24'h00fffa: mem = ok ? 8'h32 : 8'h00;
      24'h00fffb: mem = 8'h44;
      24'h00fffc: mem = 8'h46;
      24'h00fffd: mem = 8'h55;
      default:    mem = x[7:0] ^ x[15:8] ^ 8'h5a;
    endcase
  endfunction : mem
  // Frame start clears the count; sclk idles low there
  always @(posedge sclk or negedge sel_n) begin
    if (!sclk) begin
      nbits = 0;
    end else if (!sel_n) begin
      if (nbits < 80) rx[nbits/8][7-nbits%8] = di;
      nbits = nbits + 1;
    end
  end
  // Released lines must not keep the last bit
  always @(negedge sclk or posedge sel_n) if (sel_n) begin
    d1 <= ~d1;
    d0 <= ~d0;
  end else begin
    a = {rx[1], rx[2], rx[3]};
    if (rx[0] == 8'h9f && nbits >= 8) begin
      k = (nbits - 8) / 8;
      b = (k == 0) ? ID0 : (k == 1) ? ID1 : ID2;
      d1 <= b[7-nbits%8];
    end else if (rx[0] == 8'h0b && nbits >= 40) begin
      b = mem(a + 24'((nbits - 40) / 8), sig_ok);
      d1 <= b[7-nbits%8];
    end else if (rx[0] == 8'h3b && nbits >= 40) begin
      k = (nbits - 40) % 4;
      b = mem(a + 24'((nbits - 40) / 4), sig_ok);
      d1 <= b[7-2*k];
      d0 <= b[6-2*k];
    end
  end
endmodule : sff_flash_model

// File: sff_pkg.sv
// Shared constants of the serial flash fetch controller.
// Assumes a byte-wide serial flash with 24-bit addressing.
package sff_pkg;
  localparam int          CLK_HZ      = 50_000_000;
  localparam int          DUAL_HZ     = 30_000_000;
  localparam int          SCLK_HALF   = 4;
  localparam int          CEH_NS      = 50;
  localparam int          CEH_CYC     = (CEH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_COUNT   = 8'h04;
  localparam logic [7:0]  OFS_CMD_LO  = 8'h08;
  localparam logic [7:0]  OFS_CMD_HI  = 8'h0c;
  localparam logic [7:0]  OFS_RESP_LO = 8'h10;
  localparam logic [7:0]  OFS_RESP_HI = 8'h14;
  localparam int          CTRL_LAUNCH = 0;
  localparam int          CTRL_DUAL   = 1;
  localparam int          CTRL_EXT    = 2;
  localparam int          CTRL_BOOTED = 3;
  localparam int          CTRL_BUSY   = 4;
  localparam logic [7:0]  COUNT_RST   = 8'h00;
  localparam logic [63:0] BUF_RST     = 64'h0;
  localparam logic [7:0]  OP_READ     = 8'h0b;
  localparam logic [7:0]  OP_DUAL     = 8'h3b;
  localparam logic [7:0]  DUMMY_BYTE  = 8'h00;
  localparam logic        FILL_BIT    = 1'b0;
  localparam logic [23:0] BOOT_ADDR   = 24'h00fffa;
  localparam logic [31:0] BOOT_SIG    = 32'h3244_4655;
  localparam logic [2:0]  SIG_BYTES   = 3'h4;
  localparam int          HDR_BITS    = 40;
  localparam int          CACHE_BYTES = 32;
  localparam int          CMD_BYTES   = 8;
endpackage : sff_pkg
